/* File: frpc_top.sv */
// reset and power-on sequencing for a serial flash core
//////////////////////////////////////////////////////////////////////////////
// Contract
// - reset pin low at least 10 us gives a full device reset
// - after reset: standby, 3-byte addressing, volatile bits at power-on defaults
// - hardware reset aborts a running program or erase at once
// - serial output stays high impedance during the reset cycle
// - software reset needs 66h then 99h
// - power-up enters standby, not deep power-down
// - power-up clears write enable latch
// - power-on reset below write-inhibit threshold holds logic, ignores commands
// - any command other than 99h after 66h disarms (the code stays armed when a second 66h follows)
// - software reset aborts program or erase, returns to single-line standby
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module frpc_top #(
	parameter int P_PULSE_CYC = frpc_pkg::RST_PULSE_MIN_CYC,
	parameter int P_DECODE_CYC = frpc_pkg::REC_DECODE_CYC,
	parameter int P_READ_CYC = frpc_pkg::REC_READ_CYC,
	parameter int P_PROG_CYC = frpc_pkg::REC_PROG_CYC,
	parameter int P_SECTOR_CYC = frpc_pkg::REC_SECTOR_CYC,
	parameter int P_BLOCK_CYC = frpc_pkg::REC_BLOCK_CYC,
	parameter int P_CHIP_CYC = frpc_pkg::REC_CHIP_CYC,
	parameter int P_STATUS_CYC = frpc_pkg::REC_STATUS_CYC
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_link_clk,
	input wire logic i_cs_n,
	input wire logic i_cmd_bit,
	input wire logic i_reset_n,
	input wire logic i_por_low,
	input wire logic [2:0] i_op,
	input wire logic i_so_req_oe,
	output logic o_so_oe,
	output logic o_core_rst,
	output logic o_abort,
	output logic o_busy,
	output var frpc_pkg::frpc_status_t o_status,
	output var frpc_pkg::frpc_cmd_t o_cmd
);
	import frpc_pkg::*;
	//////////////////////////////////////////////////////////////////////////
	// link domain: shift the opcode, toggle on each full byte
	logic [2:0] bcnt_q, bcnt_d;
	logic [7:0] sh_q, sh_d, lbyte_q, lbyte_d;
	logic ltog_q, ltog_d, lrst_q;
	always_comb begin
		bcnt_d = bcnt_q;
		sh_d = sh_q;
		lbyte_d = lbyte_q;
		ltog_d = ltog_q;
		if (!i_cs_n) begin
			sh_d = {sh_q[6:0], i_cmd_bit};
			bcnt_d = bcnt_q + 3'h1;
			if (bcnt_q == 3'h7) begin
				lbyte_d = {sh_q[6:0], i_cmd_bit};
				ltog_d = ~ltog_q;
			end
		end
	end
	// clock stops outside frames, so the bit count is cleared by chip select itself
	always_ff @(posedge i_link_clk or posedge i_cs_n) begin
		if (i_cs_n) begin
			bcnt_q <= 3'h0;
		end else begin
			bcnt_q <= bcnt_d;
		end
	end
	// the toggle needs a known start; its reset is a registered copy of the system reset,
	// released while the link clock stands still between frames
	always_ff @(posedge i_link_clk or posedge lrst_q) begin
		if (lrst_q) begin
			ltog_q <= 1'b0;
		end else begin
			ltog_q <= ltog_d;
		end
	end
	always_ff @(posedge i_link_clk) begin
		sh_q <= sh_d;
		lbyte_q <= lbyte_d;
	end
	//////////////////////////////////////////////////////////////////////////
	// synchronisers
	logic [1:0] s_rst_q, s_por_q, s_tog_q, s_cs_q;
	logic tog_seen_q;
	always_ff @(posedge i_mclk) begin
		s_rst_q <= {s_rst_q[0], i_reset_n};
		s_por_q <= {s_por_q[0], i_por_low};
		s_tog_q <= {s_tog_q[0], ltog_q};
		s_cs_q <= {s_cs_q[0], i_cs_n};
		tog_seen_q <= s_tog_q[1];
		lrst_q <= i_srst;
	end
	wire byte_ev = s_tog_q[1] ^ tog_seen_q;
	//////////////////////////////////////////////////////////////////////////
	// main sequencer
	frpc_state_t st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [2:0] int_op_q, int_op_d;
	logic armed_q, armed_d, first_q, first_d;
	logic so_oe_q, so_oe_d, core_rst_q, core_rst_d, abort_q, abort_d, busy_q, busy_d;
	frpc_status_t stat_q, stat_d;
	frpc_cmd_t cmd_q, cmd_d;
	function automatic logic [CNT_W-1:0] rec_cycles(input logic [2:0] op);
		case (op)
			OP_READ: rec_cycles = CNT_W'(P_READ_CYC);
			OP_PROG: rec_cycles = CNT_W'(P_PROG_CYC);
			OP_SECTOR: rec_cycles = CNT_W'(P_SECTOR_CYC);
			OP_BLOCK: rec_cycles = CNT_W'(P_BLOCK_CYC);
			OP_CHIP: rec_cycles = CNT_W'(P_CHIP_CYC);
			OP_STATUS: rec_cycles = CNT_W'(P_STATUS_CYC);
			default: rec_cycles = CNT_W'(P_DECODE_CYC);
		endcase
	endfunction
	localparam frpc_status_t STAT_DEFAULT = '{standby: 1'b1, default: 1'b0};
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		int_op_d = int_op_q;
		armed_d = armed_q;
		first_d = first_q;
		stat_d = stat_q;
		abort_d = 1'b0;
		cmd_d = '0;
		case (st_q)
			FRPC_ST_POR: begin
				armed_d = 1'b0;
				stat_d = STAT_DEFAULT;
				if (!s_por_q[1]) begin
					st_d = FRPC_ST_RUN;
				end
			end
			FRPC_ST_RUN: begin
				stat_d.write_in_progress = (i_op >= OP_PROG);
				if (!s_rst_q[1]) begin
					st_d = FRPC_ST_HOLD;
					// the cycle that saw the pin fall is part of the pulse
					cnt_d = CNT_W'(1);
					int_op_d = (i_op == OP_IDLE) ? OP_DECODE : i_op;
					abort_d = (i_op >= OP_PROG);
				end else if (byte_ev && first_q) begin
					first_d = 1'b0;
					if (s_tog_q[1] != tog_seen_q && armed_q && lbyte_q == CMD_RESET) begin
						// software reset: skips the pulse check, an idle op takes the read recovery, not decode
						st_d = FRPC_ST_RECOVER;
						armed_d = 1'b0;
						abort_d = (i_op >= OP_PROG);
						stat_d = STAT_DEFAULT;
						cnt_d = rec_cycles((i_op == OP_IDLE) ? OP_READ : i_op);
					end else begin
						armed_d = (lbyte_q == CMD_RESET_ARM);
						cmd_d = '{valid: 1'b1, opcode: lbyte_q};
					end
				end
				if (s_cs_q[1]) begin
					first_d = 1'b1;
				end
			end
			FRPC_ST_HOLD: begin
				armed_d = 1'b0;
				stat_d = STAT_DEFAULT;
				if (cnt_q != CNT_W'(P_PULSE_CYC)) begin
					cnt_d = cnt_q + 1'b1;
				end
				if (s_rst_q[1]) begin
					if (cnt_q == CNT_W'(P_PULSE_CYC)) begin
						st_d = FRPC_ST_RECOVER;
						cnt_d = rec_cycles(int_op_q);
					end else begin
						st_d = FRPC_ST_RUN; // short pulse: back to run without recovery; the abort and the disarm have already taken effect
					end
				end
			end
			default: begin
				// commands from the link are dropped here
				if (cnt_q == '0) begin
					st_d = FRPC_ST_RUN;
					first_d = 1'b1;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
		endcase
		if (s_por_q[1]) begin
			st_d = FRPC_ST_POR;
			cmd_d = '0;
		end
		busy_d = (st_d != FRPC_ST_RUN);
		// taken from the next state so the core is held from the first busy cycle
		core_rst_d = (st_d != FRPC_ST_RUN);
		so_oe_d = (st_d == FRPC_ST_RUN) && i_so_req_oe;
	end
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			st_q <= FRPC_ST_POR;
			cnt_q <= '0;
			int_op_q <= OP_IDLE;
			armed_q <= 1'b0;
			first_q <= 1'b1;
			so_oe_q <= 1'b0;
			core_rst_q <= 1'b1;
			abort_q <= 1'b0;
			busy_q <= 1'b1;
			stat_q <= STAT_DEFAULT;
			cmd_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			int_op_q <= int_op_d;
			armed_q <= armed_d;
			first_q <= first_d;
			so_oe_q <= so_oe_d;
			core_rst_q <= core_rst_d;
			abort_q <= abort_d;
			busy_q <= busy_d;
			stat_q <= stat_d;
			cmd_q <= cmd_d;
		end
	end
	assign o_so_oe = so_oe_q;
	assign o_core_rst = core_rst_q;
	assign o_abort = abort_q;
	assign o_busy = busy_q;
	assign o_status = stat_q;
	assign o_cmd = cmd_q;
endmodule
`default_nettype wire

/* File: frpc_pkg.sv */
// package for the flash reset and power-on control block
package frpc_pkg;
	localparam int MCLK_MHZ = 125;
	localparam int RST_PULSE_MIN_US = 10;
	localparam int RST_PULSE_MIN_CYC = RST_PULSE_MIN_US * MCLK_MHZ;
	localparam int REC_DECODE_US = 30;
	localparam int REC_READ_US = 30;
	localparam int REC_PROG_US = 300;
	localparam int REC_SECTOR_MS = 12;
	localparam int REC_BLOCK_MS = 25;
	localparam int REC_CHIP_MS = 100;
	localparam int REC_STATUS_MS = 40;
	localparam int REC_DECODE_CYC = REC_DECODE_US * MCLK_MHZ;
	localparam int REC_READ_CYC = REC_READ_US * MCLK_MHZ;
	localparam int REC_PROG_CYC = REC_PROG_US * MCLK_MHZ;
	localparam int REC_SECTOR_CYC = REC_SECTOR_MS * 1000 * MCLK_MHZ;
	localparam int REC_BLOCK_CYC = REC_BLOCK_MS * 1000 * MCLK_MHZ;
	localparam int REC_CHIP_CYC = REC_CHIP_MS * 1000 * MCLK_MHZ;
	localparam int REC_STATUS_CYC = REC_STATUS_MS * 1000 * MCLK_MHZ;
	localparam int CNT_W = 24;
	localparam logic [7:0] CMD_RESET_ARM = 8'h66;
	localparam logic [7:0] CMD_RESET = 8'h99;
	localparam logic [2:0] OP_IDLE = 3'h0;
	localparam logic [2:0] OP_DECODE = 3'h1;
	localparam logic [2:0] OP_READ = 3'h2;
	localparam logic [2:0] OP_PROG = 3'h3;
	localparam logic [2:0] OP_SECTOR = 3'h4;
	localparam logic [2:0] OP_BLOCK = 3'h5;
	localparam logic [2:0] OP_CHIP = 3'h6;
	localparam logic [2:0] OP_STATUS = 3'h7;
	typedef enum logic [1:0] {
		FRPC_ST_POR,
		FRPC_ST_RUN,
		FRPC_ST_HOLD,
		FRPC_ST_RECOVER
	} frpc_state_t;
	typedef struct packed {
		logic standby;
		logic addr_4byte;
		logic write_enable_latch;
		logic write_in_progress;
		logic vol_lock;
	} frpc_status_t;
	typedef struct packed {
		logic valid;
		logic [7:0] opcode;
	} frpc_cmd_t;
endpackage

/* File: frpc_host_model.sv */
// host-side model: drives chip select, serial clock and opcode bits
`timescale 1ns/1ps
`default_nettype none
module frpc_host_model (
	output logic o_link_clk,
	output logic o_cs_n,
	output logic o_cmd_bit
);
	initial begin
		o_link_clk = 1'b0;
		o_cs_n = 1'b1;
		o_cmd_bit = 1'b0;
	end
	// one opcode per frame, msb first; the clock stands still between frames
	task automatic send(input logic [7:0] op);
		o_cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			o_cmd_bit = op[i];
			#24 o_link_clk = 1'b1;
			#24 o_link_clk = 1'b0;
		end
		#24 o_cs_n = 1'b1;
		o_cmd_bit = ~o_cmd_bit;
		#120;
	endtask
endmodule
`default_nettype wire

/* File: frpc_top_sva.sv */
// port-level assertions for the reset and power-on control block
`timescale 1ns/1ps
`default_nettype none
module frpc_top_sva (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_reset_n,
	input wire logic i_por_low,
	input wire logic [2:0] i_op,
	input wire logic o_so_oe,
	input wire logic o_core_rst,
	input wire logic o_abort,
	input wire logic o_busy,
	input wire frpc_pkg::frpc_status_t o_status,
	input wire frpc_pkg::frpc_cmd_t o_cmd
);
	import frpc_pkg::*;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	AST_SO_HIZ: assert property (o_busy |-> !o_so_oe)
		else $error("serial output enabled while busy");
	AST_ABORT_OP: assert property (o_abort |-> $past(i_op) >= OP_PROG)
		else $error("abort without program or erase");
	AST_ABORT_PULSE: assert property (o_abort |=> !o_abort)
		else $error("abort longer than one cycle");
	AST_POR_HOLD: assert property (i_por_low [*4] |-> o_busy && o_core_rst)
		else $error("logic running below write inhibit");
	AST_PIN_HOLD: assert property (!i_reset_n [*4] |-> o_busy && o_core_rst)
		else $error("reset pin low but core not held");
	AST_CMD_IDLE: assert property (o_cmd.valid |-> !o_busy && !o_core_rst)
		else $error("command passed while busy");
	AST_CMD_PULSE: assert property (o_cmd.valid |=> !o_cmd.valid)
		else $error("command valid longer than one cycle");
	AST_STATUS_DEF: assert property ($fell(o_busy) |-> o_status == 5'h10)
		else $error("status not at defaults after reset");
	cover property (o_abort);
	cover property (o_cmd.valid);
	cover property ($fell(o_busy));
endmodule
`default_nettype wire

/* File: flash_reset_power_on_control_tb_top.sv */
// self-checking bench for the reset and power-on control block
`timescale 1ns/1ps
`default_nettype none
module flash_reset_power_on_control_tb_top;
	import frpc_pkg::*;
	localparam int REC [8] = '{0, 20, 20, 40, 60, 70, 80, 90};
	logic i_mclk, i_srst, i_reset_n, i_por_low, i_so_req_oe, link_clk, cs_n, cmd_bit;
	logic o_so_oe, o_core_rst, o_abort, o_busy;
	logic [2:0] i_op;
	logic [7:0] opc;
	logic [31:0] seed = 32'hF26E;
	logic [7:0] exp_q [$];
	frpc_status_t o_status;
	frpc_cmd_t o_cmd;
	int fails, compares, aborts, rec;
	frpc_top #(.P_PULSE_CYC(8), .P_DECODE_CYC(REC[1]), .P_READ_CYC(REC[2]), .P_PROG_CYC(REC[3]),
		.P_SECTOR_CYC(REC[4]), .P_BLOCK_CYC(REC[5]), .P_CHIP_CYC(REC[6]),
		.P_STATUS_CYC(REC[7])) u_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_link_clk(link_clk),
		.i_cs_n(cs_n), .i_cmd_bit(cmd_bit), .i_reset_n(i_reset_n), .i_por_low(i_por_low),
		.i_op(i_op), .i_so_req_oe(i_so_req_oe), .o_so_oe(o_so_oe), .o_core_rst(o_core_rst),
		.o_abort(o_abort), .o_busy(o_busy), .o_status(o_status), .o_cmd(o_cmd));
	frpc_host_model u_host (.o_link_clk(link_clk), .o_cs_n(cs_n), .o_cmd_bit(cmd_bit));
	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task automatic wait_idle;
		rec = 0;
		while (o_busy !== 1'b0 && rec < 3000) begin
			tick(1);
			rec++;
		end
	endtask
	// a frame sent while the pin is low must be dropped
	task automatic hw_reset(input logic [2:0] op);
		int n0;
		n0 = aborts;
		i_op = op;
		i_reset_n = 1'b0;
		u_host.send(8'h5A);
		check("so_oe", 8'h00, 8'(o_so_oe));
		check("core_rst", 8'h01, 8'(o_core_rst));
		check("abort", 8'(op >= 3'h3), 8'(aborts - n0));
		i_reset_n = 1'b1;
		tick(4);
		i_op = 3'h0;
		wait_idle();
		rec += 4;
		check("recovery", 8'h01, 8'(rec >= REC[op] && rec <= REC[op] + 8));
		check("status", 8'h10, 8'(o_status));
		check("so_oe run", 8'h01, 8'(o_so_oe));
	endtask
	// the oldest expected opcode is matched against each passed command
	always @(posedge i_mclk) begin
		if (o_abort === 1'b1)
			aborts++;
		if (o_cmd.valid === 1'b1) begin
			if (exp_q.size() == 0)
				check("stray cmd", 8'h00, 8'h01);
			else
				check("opcode", exp_q.pop_front(), o_cmd.opcode);
		end
	end
	initial begin
		#400000;
		fails++;
		close_out();
	end
	initial begin
		{i_srst, i_reset_n, i_por_low, i_so_req_oe} = 4'hF;
		i_op = 3'h0;
		tick(4);
		i_srst = 1'b0;
		u_host.send(8'h3C);
		i_por_low = 1'b0;
		wait_idle();
		check("power-up status", 8'h10, 8'(o_status));
		for (int op = 1; op < 8; op++)
			hw_reset(3'(op));
		repeat (4) begin
			seed = xs(seed);
			opc = seed[7:0];
			if (opc == CMD_RESET_ARM || opc == CMD_RESET)
				opc ^= 8'h01;
			exp_q.push_back(opc);
			u_host.send(opc);
		end
		// arm, disarm with another opcode, then a lone reset opcode is an ordinary command
		i_op = 3'h4;
		exp_q.push_back(CMD_RESET_ARM);
		u_host.send(CMD_RESET_ARM);
		exp_q.push_back(8'h05);
		u_host.send(8'h05);
		exp_q.push_back(CMD_RESET);
		u_host.send(CMD_RESET);
		check("busy after disarm", 8'h00, 8'(o_busy));
		rec = aborts;
		exp_q.push_back(CMD_RESET_ARM);
		u_host.send(CMD_RESET_ARM);
		u_host.send(CMD_RESET);
		check("soft reset busy", 8'h01, 8'(o_busy));
		check("soft abort", 8'h01, 8'(aborts - rec));
		i_op = 3'h0;
		wait_idle();
		check("soft status", 8'h10, 8'(o_status));
		check("queue empty", 8'h00, 8'(exp_q.size()));
		close_out();
	end
endmodule
bind frpc_top frpc_top_sva u_sva (.i_mclk(i_mclk), .i_srst(i_srst), .i_reset_n(i_reset_n),
	.i_por_low(i_por_low), .i_op(i_op), .o_so_oe(o_so_oe), .o_core_rst(o_core_rst),
	.o_abort(o_abort), .o_busy(o_busy), .o_status(o_status), .o_cmd(o_cmd));
`default_nettype wire
